/* lsq_params.svh */
`ifndef LSQ_PARAMS_SVH
`define LSQ_PARAMS_SVH

// Register map, byte addresses (word aligned)
`define OFS_LSU_STATUS   12'h000
`define OFS_FLOW_MASK    12'h040
`define OFS_ERR_STATUS   12'h044
`define OFS_QIRQ_STATUS  12'h048
`define OFS_TRANSMIT_FIRST_DESCRIPTOR_ADDR       12'h100
`define OFS_TRANSMIT_LAST_SERVICED_ADDR        12'h200
`define OFS_RECEIVE_FIRST_DESCRIPTOR_ADDR       12'h300
// Field positions
`define BUSY_BIT         0
`define CODE_LSB         1
`define CODE_MSB         4
// Reset values
`define FLOW_MASK_RST    16'h0001
`define PTR_RST          32'h0000_0000

`endif

/* lsq_pkg.sv */
package lsq_pkg;

  // Completion codes of a load/store unit command
  typedef enum logic [3:0] {
    CC_OK        = 4'h0,
    CC_TIMEOUT   = 4'h1,
    CC_XOFF      = 4'h2,
    CC_RESP_ERR  = 4'h3,
    CC_BAD_PROG  = 4'h4,
    CC_DMA_ERR   = 4'h5,
    CC_RETRY     = 4'h6,
    CC_NO_CREDIT = 4'h7
  } code_type;

  // Completion report from one load/store unit engine
  typedef struct packed {
    logic     start;
    logic     done;
    code_type code;
  } lsu_event_type;

  // Per queue engine events
  typedef struct packed {
    logic        txEmpty;
    logic        rxExhausted;
    logic        txDescDone;
    logic [31:0] txDescAddr;
  } queue_event_type;

endpackage : lsq_pkg

/* lsu_status_queue_dma_pointers.sv */
// How it works
// - Status bit 0 is read-only busy flag
// - Status bits 4:1 hold completion code
// - Code 000b on error-free completion
// - Code 001b on non-posted response timeout
// - Code 010b on Xoff blockade, nothing sent
// - Code 011b on response error or length
// - Code 100b on unsupported or invalid fields
// - Code 101b on DMA data error
// - Code 110b on retry or semaphore refusal
// - Code 111b when no outbound credit
// - Flow mask RW bits 15:0, reset 0x01
// - Host write to tx head starts queue
// - Device zeroes tx head when queue drained
// - Write to nonzero tx head flags error
// - Completion pointer write decides interrupt deassert
// - Sixteen of each pointer, RW, reset zero
// - Rx head start, zero, error alike
//
// Decided for this implementation: the Wishbone register port and the address map.
`timescale 1ns/1ns
`default_nettype none
`include "lsq_params.svh"

module lsu_status_queue_dma_pointers #(
  parameter int NUM_LSU   = 4,
  parameter int NUM_QUEUE = 16
) (
  input  wire logic                                    clock,      // 20 MHz
  input  wire logic                                    arst_n,     // Async reset
  input  wire logic                                    wb_cyc_i,   // Bus cycle
  input  wire logic                                    wb_stb_i,   // Strobe
  input  wire logic                                    wb_we_i,    // Write
  input  wire logic [11:0]                             wb_adr_i,   // Byte address
  input  wire logic [3:0]                              wb_sel_i,   // Byte lanes
  input  wire logic [31:0]                             wb_dat_i,   // Write data
  output logic      [31:0]                             wb_dat_o,   // Read data
  output logic                                         wb_ack_o,   // Acknowledge
  input  wire lsq_pkg::lsu_event_type   [NUM_LSU-1:0]  lsuEvent,   // Engine reports
  input  wire lsq_pkg::queue_event_type [NUM_QUEUE-1:0] queueEvent, // Queue reports
  output logic      [15:0]                             flowMask,   // Flow mask to engines
  output logic      [NUM_QUEUE-1:0]                    txActive,   // Tx head nonzero
  output logic      [NUM_QUEUE-1:0]                    rxActive,   // Rx head nonzero
  output logic      [NUM_QUEUE-1:0]                    txQueueIrq  // Per queue interrupt
);
  import lsq_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Storage
  logic     [31:0] txHead_r [NUM_QUEUE];
  logic     [31:0] txComp_r [NUM_QUEUE];
  logic     [31:0] rxHead_r [NUM_QUEUE];
  logic     [31:0] lastDone_r [NUM_QUEUE];
  logic     [NUM_LSU-1:0] busy_r;
  code_type code_r [NUM_LSU];
  logic     [NUM_QUEUE-1:0] txErr_r;
  logic     [NUM_QUEUE-1:0] rxErr_r;
  logic     [31:0] rdData_nxt;
  logic     [31:0] wrMask;
  logic            access;
  logic            wrStb;

  ////////////////////////////////////////////////////////////////////////////
  // Bus strobes, one registered answer per request
  assign access = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wrStb  = access && wb_we_i;
  assign wrMask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

  // Acknowledge one cycle after the request, drop the next cycle
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
      wb_ack_o <= 1'b0;
    else
      wb_ack_o <= access;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Load/store unit busy flag and completion code
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      busy_r <= '0;
      for (int i = 0; i < NUM_LSU; i++)
        code_r[i] <= CC_OK;
    end
    else
    begin
      for (int i = 0; i < NUM_LSU; i++)
      begin
        if (lsuEvent[i].done)
        begin
          busy_r[i] <= 1'b0;
          code_r[i] <= lsuEvent[i].code;
        end                                           // Any code 0..7 captured
        else if (lsuEvent[i].start)
          busy_r[i] <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Congestion flow mask
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
      flowMask <= `FLOW_MASK_RST;
    else if (wrStb && wb_adr_i == `OFS_FLOW_MASK)
      flowMask <= (flowMask & ~wrMask[15:0]) | (wb_dat_i[15:0] & wrMask[15:0]);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Queue pointers, per queue
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      txErr_r <= '0;
      rxErr_r <= '0;
      for (int q = 0; q < NUM_QUEUE; q++)
      begin
        txHead_r[q]   <= `PTR_RST;
        txComp_r[q]   <= `PTR_RST;
        rxHead_r[q]   <= `PTR_RST;
        lastDone_r[q] <= `PTR_RST;
      end
    end
    else
    begin
      // Error flags cleared by writing one; a new error wins
      if (wrStb && wb_adr_i == `OFS_ERR_STATUS)
      begin
        txErr_r <= txErr_r & ~wb_dat_i[15:0];
        rxErr_r <= rxErr_r & ~wb_dat_i[31:16];
      end
      for (int q = 0; q < NUM_QUEUE; q++)
      begin
        if (queueEvent[q].txDescDone)
          lastDone_r[q] <= queueEvent[q].txDescAddr;
        // Tx head: write only while zero, else flag error
        if (wrStb && wb_adr_i == 12'(`OFS_TRANSMIT_FIRST_DESCRIPTOR_ADDR + 4 * q))
        begin
          if (txHead_r[q] != 32'h0)
            txErr_r[q] <= 1'b1;
          else
            txHead_r[q] <= wb_dat_i;
        end
        else if (queueEvent[q].txEmpty)
          txHead_r[q] <= `PTR_RST;
        if (wrStb && wb_adr_i == 12'(`OFS_TRANSMIT_LAST_SERVICED_ADDR + 4 * q))
          txComp_r[q] <= (txComp_r[q] & ~wrMask) | (wb_dat_i & wrMask);
        // Rx head behaves the same
        if (wrStb && wb_adr_i == 12'(`OFS_RECEIVE_FIRST_DESCRIPTOR_ADDR + 4 * q))
        begin
          if (rxHead_r[q] != 32'h0)
            rxErr_r[q] <= 1'b1;
          else
            rxHead_r[q] <= wb_dat_i;
        end
        else if (queueEvent[q].rxExhausted)
          rxHead_r[q] <= `PTR_RST;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Queue interrupt: raised on completion, dropped on matching pointer write
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
      txQueueIrq <= '0;
    else
    begin
      for (int q = 0; q < NUM_QUEUE; q++)
      begin
        if (queueEvent[q].txDescDone)
          txQueueIrq[q] <= 1'b1;
        else if (wrStb && wb_adr_i == 12'(`OFS_TRANSMIT_LAST_SERVICED_ADDR + 4 * q)
                 && wb_dat_i == lastDone_r[q])
          txQueueIrq[q] <= 1'b0;
      end
    end
  end

  // Activity outputs registered from head pointers
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      txActive <= '0;
      rxActive <= '0;
    end
    else
    begin
      for (int q = 0; q < NUM_QUEUE; q++)
      begin
        txActive[q] <= (txHead_r[q] != 32'h0);
        rxActive[q] <= (rxHead_r[q] != 32'h0);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read decode; unmapped reads return zero
  always_comb
  begin
    rdData_nxt = 32'h0;
    if (wb_adr_i < 12'(4 * NUM_LSU))
    begin
      rdData_nxt[`BUSY_BIT] = busy_r[wb_adr_i[3:2]];
      rdData_nxt[`CODE_MSB:`CODE_LSB] = code_r[wb_adr_i[3:2]];
    end
    else if (wb_adr_i == `OFS_FLOW_MASK)
      rdData_nxt[15:0] = flowMask;
    else if (wb_adr_i == `OFS_ERR_STATUS)
      rdData_nxt = {rxErr_r, txErr_r};
    else if (wb_adr_i == `OFS_QIRQ_STATUS)
      rdData_nxt[15:0] = txQueueIrq;
    else if (wb_adr_i[11:8] == 4'h1 && wb_adr_i[7:6] == 2'h0)
      rdData_nxt = txHead_r[wb_adr_i[5:2]];
    else if (wb_adr_i[11:8] == 4'h2 && wb_adr_i[7:6] == 2'h0)
      rdData_nxt = txComp_r[wb_adr_i[5:2]];
    else if (wb_adr_i[11:8] == 4'h3 && wb_adr_i[7:6] == 2'h0)
      rdData_nxt = rxHead_r[wb_adr_i[5:2]];
  end

  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
      wb_dat_o <= 32'h0;
    else if (access && !wb_we_i)
      wb_dat_o <= rdData_nxt;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  // Host write to one queue's tx head pointer
  sequence s_txHeadWrite(int q);
    wrStb && wb_adr_i == 12'(`OFS_TRANSMIT_FIRST_DESCRIPTOR_ADDR + 4 * q);
  endsequence

  // Host write to one queue's rx head pointer
  sequence s_rxHeadWrite(int q);
    wrStb && wb_adr_i == 12'(`OFS_RECEIVE_FIRST_DESCRIPTOR_ADDR + 4 * q);
  endsequence

  // Host write to one queue's tx completion pointer
  sequence s_compWrite(int q);
    wrStb && wb_adr_i == 12'(`OFS_TRANSMIT_LAST_SERVICED_ADDR + 4 * q);
  endsequence

  // Host read of one unit's status word
  sequence s_statusRead(int u);
    access && !wb_we_i && wb_adr_i == 12'(4 * u);
  endsequence

  // Bus, flow mask and error flag clear checks
  chk_mask_write: assert property (@(posedge clock) disable iff (!arst_n)
    wrStb && wb_adr_i == `OFS_FLOW_MASK && wb_sel_i == 4'hF |=> flowMask == $past(wb_dat_i[15:0]))
    else $error("flow mask write lost");

  chk_mask_reserved: assert property (@(posedge clock) disable iff (!arst_n)
    access && !wb_we_i && wb_adr_i == `OFS_FLOW_MASK |=> wb_dat_o[31:16] == 16'h0)
    else $error("flow mask reserved bits not zero");

  chk_mask_partial: assert property (@(posedge clock) disable iff (!arst_n)
    wrStb && wb_adr_i == `OFS_FLOW_MASK && wb_sel_i == 4'h1
    |=> flowMask == {$past(flowMask[15:8]), $past(wb_dat_i[7:0])})
    else $error("flow mask byte lane write wrong");

  chk_ack_pulse: assert property (@(posedge clock) disable iff (!arst_n)
    access |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack not a single pulse");

  chk_dat_held: assert property (@(posedge clock) disable iff (!arst_n)
    !(access && !wb_we_i) |=> $stable(wb_dat_o))
    else $error("read data changed without a read");

  chk_err_clear: assert property (@(posedge clock) disable iff (!arst_n)
    wrStb && wb_adr_i == `OFS_ERR_STATUS |=> (txErr_r & $past(wb_dat_i[15:0])) == 16'h0)
    else $error("tx error flag not cleared");

  ////////////////////////////////////////////////////////////////////////////
  // Per unit busy flag and completion code checks
  for (genvar u = 0; u < NUM_LSU; u++)
  begin : gen_unit_chk
    chk_busy_done_clears: assert property (@(posedge clock) disable iff (!arst_n)
      lsuEvent[u].done |=> !busy_r[u])
      else $error("busy not cleared on done");

    chk_code_captured: assert property (@(posedge clock) disable iff (!arst_n)
      lsuEvent[u].done |=> code_r[u] == $past(lsuEvent[u].code))
      else $error("completion code not captured");

    chk_busy_set_start: assert property (@(posedge clock) disable iff (!arst_n)
      lsuEvent[u].start && !lsuEvent[u].done |=> busy_r[u])
      else $error("busy not set on start");

    chk_status_held: assert property (@(posedge clock) disable iff (!arst_n)
      !lsuEvent[u].start && !lsuEvent[u].done
      |=> busy_r[u] == $past(busy_r[u]) && code_r[u] == $past(code_r[u]))
      else $error("status changed without engine report");

    chk_status_read: assert property (@(posedge clock) disable iff (!arst_n)
      s_statusRead(u) |=> wb_dat_o[`BUSY_BIT] == $past(busy_r[u])
        && wb_dat_o[`CODE_MSB:`CODE_LSB] == $past(code_r[u]) && wb_dat_o[31:5] == 27'h0)
      else $error("status word read wrong");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per queue pointer, activity and interrupt checks
  for (genvar g = 0; g < NUM_QUEUE; g++)
  begin : gen_queue_chk
    // Tx head pointer
    chk_head_busy_error: assert property (@(posedge clock) disable iff (!arst_n)
      s_txHeadWrite(g) ##0 (txHead_r[g] != 32'h0)
      |=> txErr_r[g] && txHead_r[g] == $past(txHead_r[g]))
      else $error("write to busy tx head not refused");

    chk_head_start: assert property (@(posedge clock) disable iff (!arst_n)
      s_txHeadWrite(g) ##0 (txHead_r[g] == 32'h0)
      |=> txHead_r[g] == $past(wb_dat_i))
      else $error("tx head write not taken");

    chk_head_drained: assert property (@(posedge clock) disable iff (!arst_n)
      queueEvent[g].txEmpty && !(wrStb && wb_adr_i == 12'(`OFS_TRANSMIT_FIRST_DESCRIPTOR_ADDR + 4 * g))
      |=> txHead_r[g] == 32'h0)
      else $error("tx head not zeroed");

    // Rx head pointer
    chk_rx_head_error: assert property (@(posedge clock) disable iff (!arst_n)
      s_rxHeadWrite(g) ##0 (rxHead_r[g] != 32'h0)
      |=> rxErr_r[g] && rxHead_r[g] == $past(rxHead_r[g]))
      else $error("write to busy rx head not refused");

    chk_rx_head_start: assert property (@(posedge clock) disable iff (!arst_n)
      s_rxHeadWrite(g) ##0 (rxHead_r[g] == 32'h0)
      |=> rxHead_r[g] == $past(wb_dat_i))
      else $error("rx head write not taken");

    chk_rx_head_drained: assert property (@(posedge clock) disable iff (!arst_n)
      queueEvent[g].rxExhausted && !(wrStb && wb_adr_i == 12'(`OFS_RECEIVE_FIRST_DESCRIPTOR_ADDR + 4 * g))
      |=> rxHead_r[g] == 32'h0)
      else $error("rx head not zeroed");

    // Completion pointer and interrupt
    chk_comp_write: assert property (@(posedge clock) disable iff (!arst_n)
      s_compWrite(g) ##0 (wb_sel_i == 4'hF)
      |=> txComp_r[g] == $past(wb_dat_i))
      else $error("completion pointer write lost");

    chk_irq_raise: assert property (@(posedge clock) disable iff (!arst_n)
      queueEvent[g].txDescDone |=> txQueueIrq[g])
      else $error("irq not raised on completion");

    chk_irq_release: assert property (@(posedge clock) disable iff (!arst_n)
      s_compWrite(g) ##0 (wb_dat_i != lastDone_r[g] && txQueueIrq[g])
      |=> txQueueIrq[g])
      else $error("irq dropped on mismatched pointer");

    chk_irq_clear: assert property (@(posedge clock) disable iff (!arst_n)
      s_compWrite(g) ##0 (wb_dat_i == lastDone_r[g] && !queueEvent[g].txDescDone)
      |=> !txQueueIrq[g])
      else $error("irq kept on matching pointer");

    // Activity outputs
    chk_tx_active: assert property (@(posedge clock) disable iff (!arst_n)
      txHead_r[g] != 32'h0 |=> txActive[g])
      else $error("tx activity not shown");

    chk_rx_active: assert property (@(posedge clock) disable iff (!arst_n)
      rxHead_r[g] != 32'h0 |=> rxActive[g])
      else $error("rx activity not shown");
  end

endmodule : lsu_status_queue_dma_pointers
`default_nettype wire

/* lsq_engine_model.sv */
`timescale 1ns/1ns
`default_nettype none

module lsq_engine_model
  import lsq_pkg::*;
(
  input  wire logic                          clock,      // Bench clock
  output var  lsq_pkg::lsu_event_type [3:0]   lsuEvent,   // Engine reports
  output var  lsq_pkg::queue_event_type [15:0] queueEvent  // Queue reports
);
  // Quiet engines until a pulse is asked for
  initial
  begin
    lsuEvent = '0;
    queueEvent = '0;
  end

  // One-cycle command start or finish with its outcome
  task automatic lsu_report(input int unit, input logic st, input code_type cd);
    @(posedge clock);
    lsuEvent[unit] <= '{start: st, done: !st, code: cd};
    @(posedge clock);
    lsuEvent[unit] <= '0;
  endtask : lsu_report

  // One-cycle queue report: drained, exhausted or descriptor done
  task automatic queue_report(input int q, input logic [2:0] kind, input logic [31:0] adr);
    @(posedge clock);
    queueEvent[q] <= '{txEmpty: kind[2], rxExhausted: kind[1],
                       txDescDone: kind[0], txDescAddr: adr};
    @(posedge clock);
    queueEvent[q] <= '0;
  endtask : queue_report
endmodule : lsq_engine_model

`default_nettype wire

/* lsu_status_queue_dma_pointers_bench.sv */
`timescale 1ns/1ns
`default_nettype none
`include "lsq_params.svh"
`define CHECK(what, exp, got) \
  begin \
    samples_checked++; \
    if ((got) !== (exp)) \
    begin \
      mismatches++; \
      $display("MISMATCH %s expected %0h seen %0h", what, exp, got); \
    end \
  end

module lsu_status_queue_dma_pointers_bench;
  import lsq_pkg::*;
  logic                    clock = 1'b0;
  logic                    arst_n = 1'b0;
  logic                    wbCyc = 1'b0;
  logic                    wbStb = 1'b0;
  logic                    wbWe = 1'b0;
  logic [11:0]             wbAdr = '0;
  logic [3:0]              wbSel = 4'hF;
  logic [31:0]             wbWdat = '0;
  logic [31:0]             wbRdat;
  logic                    wbAck;
  logic [15:0]             flowMask;
  logic [15:0]             txActive;
  logic [15:0]             rxActive;
  logic [15:0]             txQueueIrq;
  lsu_event_type   [3:0]   lsuEvent;
  queue_event_type [15:0]  queueEvent;
  int                      mismatches = 0;
  int                      samples_checked = 0;
  logic [31:0]             rd;

  ////////////////////////////////////////////////////////////////////////////
  // Clock
  always #25 clock = ~clock;

  lsu_status_queue_dma_pointers DUT (
    .clock(clock), .arst_n(arst_n), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb),
    .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbWdat),
    .wb_dat_o(wbRdat), .wb_ack_o(wbAck), .lsuEvent(lsuEvent),
    .queueEvent(queueEvent), .flowMask(flowMask), .txActive(txActive),
    .rxActive(rxActive), .txQueueIrq(txQueueIrq)
  );

  lsq_engine_model ENG (.clock(clock), .lsuEvent(lsuEvent), .queueEvent(queueEvent));

  ////////////////////////////////////////////////////////////////////////////
  // Verdict and end of run
  task automatic complete_run;
    if (mismatches == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : complete_run

  // Classic single bus cycle, held until ack is sampled
  task automatic bus(input logic we, input logic [11:0] adr, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge clock);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= we;
    wbAdr <= adr;
    wbWdat <= wd;
    do
    begin
      @(posedge clock);
      n++;
    end
    while (wbAck !== 1'b1 && n < 20);
    rd = wbRdat;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    if (wbAck !== 1'b1)
    begin
      mismatches++;
      complete_run();
    end
  endtask : bus

  // Read a word and compare it
  task automatic rdc(input logic [11:0] adr, input logic [31:0] exp);
    bus(1'b0, adr, '0);
    `CHECK("read word", exp, rd)
  endtask : rdc

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    repeat (2) @(posedge clock);
    arst_n <= 1'b1;
    rdc(`OFS_LSU_STATUS + 12'h00C, 32'h0);
    rdc(`OFS_FLOW_MASK, 32'h1);
    rdc(`OFS_TRANSMIT_FIRST_DESCRIPTOR_ADDR + 12'h03C, 32'h0);
    rdc(`OFS_TRANSMIT_LAST_SERVICED_ADDR + 12'h004, 32'h0);
    rdc(`OFS_RECEIVE_FIRST_DESCRIPTOR_ADDR + 12'h020, 32'h0);
    rdc(12'h0FC, 32'h0);
    bus(1'b1, `OFS_FLOW_MASK, 32'hFFFF_FFFF);
    rdc(`OFS_FLOW_MASK, 32'h0000_FFFF);
    `CHECK("flowMask", 16'hFFFF, flowMask)
    wbSel <= 4'h1;
    bus(1'b1, `OFS_FLOW_MASK, 32'h0000_0000);
    wbSel <= 4'hF;
    rdc(`OFS_FLOW_MASK, 32'h0000_FF00);
    bus(1'b1, `OFS_LSU_STATUS, 32'h1F);
    rdc(`OFS_LSU_STATUS, 32'h0);
    // Every completion code on rotating units, busy seen first
    for (int c = 0; c < 8; c++)
    begin
      ENG.lsu_report(c % 4, 1'b1, code_type'(c));
      bus(1'b0, 12'(4 * (c % 4)), '0);
      `CHECK("busy", 1'b1, rd[0])
      ENG.lsu_report(c % 4, 1'b0, code_type'(c));
      rdc(12'(4 * (c % 4)), 32'(c) << 1);
    end
    bus(1'b1, `OFS_TRANSMIT_FIRST_DESCRIPTOR_ADDR + 12'h00C, 32'h1000);
    rdc(`OFS_TRANSMIT_FIRST_DESCRIPTOR_ADDR + 12'h00C, 32'h1000);
    `CHECK("txActive", 16'h0008, txActive)
    bus(1'b1, `OFS_TRANSMIT_FIRST_DESCRIPTOR_ADDR + 12'h00C, 32'h2000);
    rdc(`OFS_TRANSMIT_FIRST_DESCRIPTOR_ADDR + 12'h00C, 32'h1000);
    rdc(`OFS_ERR_STATUS, 32'h0000_0008);
    bus(1'b1, `OFS_ERR_STATUS, 32'h0000_0008);
    rdc(`OFS_ERR_STATUS, 32'h0);
    ENG.queue_report(3, 3'b100, '0);
    rdc(`OFS_TRANSMIT_FIRST_DESCRIPTOR_ADDR + 12'h00C, 32'h0);
    bus(1'b1, `OFS_RECEIVE_FIRST_DESCRIPTOR_ADDR + 12'h014, 32'h3000);
    bus(1'b1, `OFS_RECEIVE_FIRST_DESCRIPTOR_ADDR + 12'h014, 32'h4000);
    rdc(`OFS_ERR_STATUS, 32'h0020_0000);
    `CHECK("rxActive", 16'h0020, rxActive)
    ENG.queue_report(5, 3'b010, '0);
    rdc(`OFS_RECEIVE_FIRST_DESCRIPTOR_ADDR + 12'h014, 32'h0);
    ENG.queue_report(2, 3'b001, 32'h40);
    rdc(`OFS_QIRQ_STATUS, 32'h4);
    bus(1'b1, `OFS_TRANSMIT_LAST_SERVICED_ADDR + 12'h008, 32'h44);
    `CHECK("irq kept", 16'h0004, txQueueIrq)
    bus(1'b1, `OFS_TRANSMIT_LAST_SERVICED_ADDR + 12'h008, 32'h40);
    rdc(`OFS_TRANSMIT_LAST_SERVICED_ADDR + 12'h008, 32'h40);
    `CHECK("irq cleared", 16'h0000, txQueueIrq)
    complete_run();
  end
endmodule : lsu_status_queue_dma_pointers_bench

`default_nettype wire
